// *** core/ueg_consts.vh ***
// Constants for the USB event collection and global control block.
// Assumes a single 250 MHz reference clock and an 8-bit special function register port.
`ifndef UEG_CONSTS_VH
`define UEG_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define UEG_CON_ADDR 8'hbc
`define UEG_CON_RESET 8'h00

// ----------------------------------------
// Global control fields
// ----------------------------------------
`define UEG_BIT_ENABLE 7
`define UEG_BIT_GATE 6
`define UEG_BIT_SEND_WAKE 5
`define UEG_BIT_RSVD 4
`define UEG_BIT_WAKE_BUSY 3
`define UEG_BIT_WAKE_ALLOW 2
`define UEG_BIT_CONFIG 1
`define UEG_BIT_ADDR_VALID 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define UEG_CLK_PS 4000
`define UEG_BUS_RESET_PS 2666667
`define UEG_BUS_RESET_CYC ((`UEG_BUS_RESET_PS + `UEG_CLK_PS - 1) / `UEG_CLK_PS)
`define UEG_IDLE_MS 3
`define UEG_SUSP_WAKE_MS 5
`define UEG_RESUME_MS 2
`define UEG_CYC_PER_MS 250000

`endif

// *** core/ueg_ctrl.v ***
// USB event collection, interrupt merge and global control register.
// Assumes the USB engine gives one-cycle event pulses on this clock and firmware
// gives one-cycle flag clear pulses; bus pins arrive asynchronously.
//
// Behaviour
// - Two priority bits form a four-level priority, 0 lowest, 3 highest.
// - All endpoint and bus flags merge into one USB interrupt request.
// - Set in_sent_flag when host acknowledges an IN packet from the endpoint.
// - Set out_bank0_flag when an accepted OUT packet lands in bank 0.
// - Set out_bank1_flag only on ping-pong endpoints for bank 1 packets.
// - Set setup_received_flag whenever an endpoint accepts a SETUP packet.
// - Stall_sent_flag set after requested STALL, non-isochronous only; SETUP clears it.
// - Set frame_start_flag on each received start-of-frame packet.
// - Set wake_cpu_flag on resume signalling after bus suspend.
// - Set suspend_flag when a bus suspend condition is detected.
// - Writing one to controller_enable, bit 7, switches the controller on.
// - Clearing controller_enable resets controller, transceiver off, clocks cut.
// - Clock_gate_suspend, bit 6, blocks the 48 MHz clock; resume detection stays.
// - Send_wake_request drives resume only if allowed, clocks run, suspended 5 ms.
// - Bit 4 always reads zero; firmware never writes one.
// - Wake_in_progress set during upstream resume, cleared when it is sent.
// - Configured_flag clears on hardware reset and on 32-bit-time SE0 bus reset.
// - Suspend_flag only after more than 3 ms idle with controller and clocks on.
`timescale 1ns/1ps
`include "ueg_consts.vh"

module ueg_ctrl #(
  parameter N_EP = 8,
  parameter CW = 22,
  parameter IDLE_CYC = `UEG_IDLE_MS * `UEG_CYC_PER_MS,
  parameter SUSP_WAKE_CYC = `UEG_SUSP_WAKE_MS * `UEG_CYC_PER_MS,
  parameter RESUME_CYC = `UEG_RESUME_MS * `UEG_CYC_PER_MS,
  parameter BUS_RESET_CYC = `UEG_BUS_RESET_CYC
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  output reg [7:0] o_sfr_rdata,
  input wire i_usb_prio_high_bit,
  input wire i_usb_prio_low_bit,
  input wire [N_EP-1:0] i_ep_pingpong,
  input wire [N_EP-1:0] i_ep_iso,
  input wire [N_EP-1:0] i_stall_request,
  input wire [N_EP-1:0] i_in_ack_ev,
  input wire [N_EP-1:0] i_out_bank0_ev,
  input wire [N_EP-1:0] i_out_bank1_ev,
  input wire [N_EP-1:0] i_setup_ev,
  input wire [N_EP-1:0] i_stall_ev,
  input wire i_sof_ev,
  input wire [N_EP-1:0] i_in_sent_clr,
  input wire [N_EP-1:0] i_out_bank0_clr,
  input wire [N_EP-1:0] i_out_bank1_clr,
  input wire [N_EP-1:0] i_setup_received_clr,
  input wire [N_EP-1:0] i_stall_sent_clr,
  input wire i_frame_start_clr,
  input wire i_wake_cpu_clr,
  input wire i_suspend_clr,
  input wire [N_EP-1:0] i_ep_irq_en,
  input wire [2:0] i_bus_irq_en,
  input wire i_dp,
  input wire i_dm,
  output reg [N_EP-1:0] o_in_sent_flag,
  output reg [N_EP-1:0] o_out_bank0_flag,
  output reg [N_EP-1:0] o_out_bank1_flag,
  output reg [N_EP-1:0] o_setup_received_flag,
  output reg [N_EP-1:0] o_stall_sent_flag,
  output reg o_frame_start_flag,
  output reg o_wake_cpu_flag,
  output reg o_suspend_flag,
  output reg o_usb_irq,
  output reg [1:0] o_usb_irq_prio,
  output reg o_ctrl_rst,
  output reg o_xcvr_en,
  output reg o_usb_clk_en,
  output reg o_bus_reset,
  output reg o_dp,
  output reg o_dm,
  output reg o_pad_oe
);

  // ----------------------------------------
  // Global control register
  // ----------------------------------------
  reg ctrl_enable, clk_gate, send_wake, wake_busy;
  reg wake_allow, configured, addr_valid;
  wire con_wr = i_sfr_wr && (i_sfr_addr == `UEG_CON_ADDR);
  wire clk_run = ctrl_enable && !clk_gate;
  wire [7:0] con_value = {ctrl_enable, clk_gate, send_wake, 1'b0,
    wake_busy, wake_allow, configured, addr_valid};

  // ----------------------------------------
  // Bus pin synchronisers and line states
  // ----------------------------------------
  reg [1:0] dp_sync, dm_sync;

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      dp_sync <= 2'h0;
      dm_sync <= 2'h0;
    end
    else
    begin
      dp_sync <= {dp_sync[0], i_dp};
      dm_sync <= {dm_sync[0], i_dm};
    end
  end

  // Full-speed idle is the J state
  wire line_idle = dp_sync[1] && !dm_sync[1];
  wire line_se0 = !dp_sync[1] && !dm_sync[1];

  // ----------------------------------------
  // Bus state: suspend, resume, bus reset, upstream resume
  // ----------------------------------------
  reg [CW-1:0] idle_cnt, susp_cnt, resume_cnt, se0_cnt;
  reg bus_susp, wake_done;
  wire bus_reset_hit = line_se0 && (se0_cnt == BUS_RESET_CYC[CW-1:0] - 1'b1);
  wire wake_go = send_wake && wake_allow && clk_run && bus_susp && !wake_busy && !wake_done &&
    (susp_cnt >= SUSP_WAKE_CYC[CW-1:0]);

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !ctrl_enable)
    begin
      idle_cnt <= {CW{1'b0}};
      susp_cnt <= {CW{1'b0}};
      resume_cnt <= {CW{1'b0}};
      se0_cnt <= {CW{1'b0}};
      bus_susp <= 1'b0;
      wake_busy <= 1'b0;
      wake_done <= 1'b0;
      o_bus_reset <= 1'b0;
    end
    else
    begin
      o_bus_reset <= bus_reset_hit;
      // Bus reset needs the running clock; SE0 during gating is a resume anyway
      if (line_se0 && clk_run && se0_cnt != BUS_RESET_CYC[CW-1:0])
        se0_cnt <= se0_cnt + 1'b1;
      else if (!line_se0)
        se0_cnt <= {CW{1'b0}};
      // Suspend timer runs only with clocks on; more than the idle time is required
      if (!line_idle || !clk_run || bus_susp)
        idle_cnt <= {CW{1'b0}};
      else if (idle_cnt != IDLE_CYC[CW-1:0])
        idle_cnt <= idle_cnt + 1'b1;
      if (!bus_susp && clk_run && line_idle && idle_cnt == IDLE_CYC[CW-1:0])
        bus_susp <= 1'b1;
      else if (bus_susp && !line_idle && !wake_busy)
        bus_susp <= 1'b0;
      else if (wake_busy && resume_cnt == RESUME_CYC[CW-1:0] - 1'b1)
        bus_susp <= 1'b0;
      if (!bus_susp)
        susp_cnt <= {CW{1'b0}};
      else if (susp_cnt != SUSP_WAKE_CYC[CW-1:0])
        susp_cnt <= susp_cnt + 1'b1;
      if (wake_go)
      begin
        wake_busy <= 1'b1;
        resume_cnt <= {CW{1'b0}};
      end
      else if (wake_busy)
      begin
        resume_cnt <= resume_cnt + 1'b1;
        if (resume_cnt == RESUME_CYC[CW-1:0] - 1'b1)
        begin
          wake_busy <= 1'b0;
          wake_done <= 1'b1;
        end
      end
      // One resume per request; firmware must drop the bit to arm another
      if (!send_wake && !wake_busy)
        wake_done <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes and read-back
  // ----------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_enable <= 1'b0;
      clk_gate <= 1'b0;
      send_wake <= 1'b0;
      wake_allow <= 1'b0;
      configured <= 1'b0;
      addr_valid <= 1'b0;
      o_sfr_rdata <= 8'h00;
    end
    else
    begin
      if (con_wr)
      begin
        ctrl_enable <= i_sfr_wdata[`UEG_BIT_ENABLE];
        clk_gate <= i_sfr_wdata[`UEG_BIT_GATE];
        send_wake <= i_sfr_wdata[`UEG_BIT_SEND_WAKE];
        wake_allow <= i_sfr_wdata[`UEG_BIT_WAKE_ALLOW];
        configured <= i_sfr_wdata[`UEG_BIT_CONFIG];
        addr_valid <= i_sfr_wdata[`UEG_BIT_ADDR_VALID];
      end
      // Bus reset wins over a same-cycle firmware write
      if (bus_reset_hit)
      begin
        configured <= 1'b0;
        addr_valid <= 1'b0;
      end
      if (i_sfr_rd && i_sfr_addr == `UEG_CON_ADDR)
        o_sfr_rdata <= con_value;
      else
        o_sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Controller power and clock outputs
  // ----------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_ctrl_rst <= 1'b1;
      o_xcvr_en <= 1'b0;
      o_usb_clk_en <= 1'b0;
      o_dp <= 1'b0;
      o_dm <= 1'b0;
      o_pad_oe <= 1'b0;
      o_usb_irq_prio <= 2'h0;
    end
    else
    begin
      o_ctrl_rst <= !ctrl_enable;
      o_xcvr_en <= ctrl_enable;
      o_usb_clk_en <= clk_run;
      // Resume signalling is the K state driven upstream
      o_dp <= 1'b0;
      o_dm <= wake_busy;
      o_pad_oe <= wake_busy;
      // Priority belongs to the core's interrupt system, so disabling the controller keeps it
      o_usb_irq_prio <= {i_usb_prio_high_bit, i_usb_prio_low_bit};
    end
  end

  // ----------------------------------------
  // Per-endpoint event flags; set wins over clear
  // ----------------------------------------
  wire [N_EP-1:0] ep_any;
  genvar g;
  generate
    for (g = 0; g < N_EP; g = g + 1)
    begin : g_ep
      wire stall_ok = i_stall_ev[g] && i_stall_request[g] && !i_ep_iso[g];
      always @(posedge i_ref_clk)
      begin
        if (i_sys_rst || !ctrl_enable)
        begin
          o_in_sent_flag[g] <= 1'b0;
          o_out_bank0_flag[g] <= 1'b0;
          o_out_bank1_flag[g] <= 1'b0;
          o_setup_received_flag[g] <= 1'b0;
          o_stall_sent_flag[g] <= 1'b0;
        end
        else
        begin
          if (clk_run && i_in_ack_ev[g])
            o_in_sent_flag[g] <= 1'b1;
          else if (i_in_sent_clr[g])
            o_in_sent_flag[g] <= 1'b0;
          if (clk_run && i_out_bank0_ev[g])
            o_out_bank0_flag[g] <= 1'b1;
          else if (i_out_bank0_clr[g])
            o_out_bank0_flag[g] <= 1'b0;
          if (clk_run && i_out_bank1_ev[g] && i_ep_pingpong[g])
            o_out_bank1_flag[g] <= 1'b1;
          else if (i_out_bank1_clr[g])
            o_out_bank1_flag[g] <= 1'b0;
          if (clk_run && i_setup_ev[g])
            o_setup_received_flag[g] <= 1'b1;
          else if (i_setup_received_clr[g])
            o_setup_received_flag[g] <= 1'b0;
          if (clk_run && stall_ok)
            o_stall_sent_flag[g] <= 1'b1;
          else if ((clk_run && i_setup_ev[g]) || i_stall_sent_clr[g])
            o_stall_sent_flag[g] <= 1'b0;
        end
      end
      assign ep_any[g] = i_ep_irq_en[g] && (o_in_sent_flag[g] || o_out_bank0_flag[g] ||
        o_out_bank1_flag[g] || o_setup_received_flag[g] || o_stall_sent_flag[g]);
    end
  endgenerate

  // ----------------------------------------
  // Bus event flags and interrupt merge
  // ----------------------------------------
  wire susp_set = !bus_susp && clk_run && line_idle && idle_cnt == IDLE_CYC[CW-1:0];
  // Resume detection keeps working while the 48 MHz clock is gated
  wire wake_set = bus_susp && !line_idle && !wake_busy;

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !ctrl_enable)
    begin
      o_frame_start_flag <= 1'b0;
      o_wake_cpu_flag <= 1'b0;
      o_suspend_flag <= 1'b0;
      o_usb_irq <= 1'b0;
    end
    else
    begin
      if (clk_run && i_sof_ev)
        o_frame_start_flag <= 1'b1;
      else if (i_frame_start_clr)
        o_frame_start_flag <= 1'b0;
      if (wake_set)
        o_wake_cpu_flag <= 1'b1;
      else if (i_wake_cpu_clr)
        o_wake_cpu_flag <= 1'b0;
      if (susp_set)
        o_suspend_flag <= 1'b1;
      else if (i_suspend_clr)
        o_suspend_flag <= 1'b0;
      o_usb_irq <= (|ep_any) || (i_bus_irq_en[0] && o_frame_start_flag) ||
        (i_bus_irq_en[1] && o_wake_cpu_flag) || (i_bus_irq_en[2] && o_suspend_flag);
    end
  end

endmodule // ueg_ctrl

// *** bench/ueg_checker.sv ***
// Checker: timing relations on the ports of the event and control block.
// Assumes one clock, registered outputs and a bench that never writes bit 4.
`timescale 1ns/1ps
module ueg_checker #(parameter N_EP = 8) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] o_sfr_rdata,
  input wire i_usb_prio_high_bit,
  input wire i_usb_prio_low_bit,
  input wire [N_EP-1:0] i_ep_pingpong,
  input wire [N_EP-1:0] i_ep_iso,
  input wire [N_EP-1:0] i_setup_ev,
  input wire [N_EP-1:0] i_stall_ev,
  input wire [N_EP-1:0] i_setup_received_clr,
  input wire [N_EP-1:0] i_ep_irq_en,
  input wire [N_EP-1:0] o_out_bank1_flag,
  input wire [N_EP-1:0] o_setup_received_flag,
  input wire [N_EP-1:0] o_stall_sent_flag,
  input wire o_usb_irq,
  input wire [1:0] o_usb_irq_prio,
  input wire o_ctrl_rst,
  input wire o_xcvr_en,
  input wire o_usb_clk_en,
  input wire o_dp,
  input wire o_dm,
  input wire o_pad_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // A register write may reset the flags, so sticky checks skip two cycles after one
  wire reg_wr = i_sfr_wr && i_sfr_addr == 8'hbc;
  prio_map_a: assert property (1 |=> o_usb_irq_prio == $past({i_usb_prio_high_bit, i_usb_prio_low_bit}))
    else $error("priority level wrong");
  setup_set_a: assert property (i_setup_ev[0] && o_usb_clk_en |=> o_setup_received_flag[0])
    else $error("setup flag not set");
  flag_sticky_a: assert property (o_setup_received_flag[0] && !i_setup_received_clr[0] && !o_ctrl_rst
    && !reg_wr && !$past(reg_wr) |=> o_setup_received_flag[0]) else $error("flag dropped");
  irq_merge_a: assert property (o_setup_received_flag[0] && i_ep_irq_en[0] && !o_ctrl_rst && !reg_wr
    && !$past(reg_wr) |=> o_usb_irq) else $error("request missing");
  bank1_only_a: assert property (!i_ep_pingpong[0] && !o_out_bank1_flag[0] |=> !o_out_bank1_flag[0])
    else $error("bank 1 flag on plain endpoint");
  stall_iso_a: assert property (i_ep_iso[6] && !o_stall_sent_flag[6] |=> !o_stall_sent_flag[6])
    else $error("stall flag on iso endpoint");
  stall_clear_a: assert property (o_stall_sent_flag[5] && i_setup_ev[5] && !i_stall_ev[5] && o_usb_clk_en
    |=> !o_stall_sent_flag[5]) else $error("stall flag kept");
  ctrl_outs_a: assert property (reg_wr ##1 !reg_wr |=> o_xcvr_en == $past(i_sfr_wdata[7], 2)
    && o_ctrl_rst == !$past(i_sfr_wdata[7], 2) && o_usb_clk_en == ($past(i_sfr_wdata[7], 2)
    && !$past(i_sfr_wdata[6], 2))) else $error("control outputs wrong");
  rsvd_zero_a: assert property (i_sfr_rd |=> !o_sfr_rdata[4]) else $error("bit 4 read one");
  pad_k_a: assert property ($rose(o_pad_oe) |-> (o_pad_oe && !o_dp && o_dm) [*8])
    else $error("resume drive wrong");
endmodule // ueg_checker
bind ueg_ctrl ueg_checker #(.N_EP(N_EP)) ueg_checker_i (.*);

// *** bench/ueg_host_model.sv ***
// Host side of the bus: drives the line pair that the block listens to.
// Assumes the bench picks the line state; the block's own drive is merged outside.
`timescale 1ns/1ps
module ueg_host_model (
  input wire i_ref_clk,
  input wire [1:0] i_mode,
  output logic o_dp,
  output logic o_dm
);
  // Mode 0 idle J, 1 SE0, 2 resume K, 3 traffic toggling K and J each cycle, never idle for two cycles running
  initial {o_dp, o_dm} = 2'b10;
  always @(posedge i_ref_clk)
  begin
    case (i_mode)
      2'd0: {o_dp, o_dm} <= 2'b10;
      2'd1: {o_dp, o_dm} <= 2'b00;
      2'd2: {o_dp, o_dm} <= 2'b01;
      default: {o_dp, o_dm} <= {!o_dp, o_dp};
    endcase
  end
endmodule // ueg_host_model

// *** bench/tb_usb_event_and_global_control.sv ***
// Testbench: register, event, suspend, resume and bus reset scenarios.
// Assumes short test counts on the design; flags are driven as plain ports.
`timescale 1ns/1ps
module tb_usb_event_and_global_control;
  logic clk = 0, rst = 1, wr = 0, rd = 0, hi = 0, lo = 0;
  logic [7:0] ad = 8'hbc, wd = 8'h00, pp = 8'h10, iso = 8'h40, sr = 8'h60, ie = 8'hff;
  logic [7:0] p [12] = '{default: 8'h00};
  logic [1:0] mode = 2'd3;
  wire [7:0] rdv, fi, f0, f1, fs, fst;
  wire [1:0] pr;
  wire fr, fw, fsp, irq, crst, xen, cen, brst, odp, odm, poe, hdp, hdm;
  int n_mismatch = 0, compares = 0, k;
  // The device wins the wire while it drives resume
  wire dp = poe ? odp : hdp;
  wire dm = poe ? odm : hdm;
  ueg_host_model ueg_host_model_i (.i_ref_clk(clk), .i_mode(mode), .o_dp(hdp), .o_dm(hdm));
  ueg_ctrl #(.IDLE_CYC(20), .SUSP_WAKE_CYC(30), .RESUME_CYC(10), .BUS_RESET_CYC(8)) ueg_ctrl_i (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_sfr_addr(ad), .i_sfr_wdata(wd), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .o_sfr_rdata(rdv), .i_usb_prio_high_bit(hi), .i_usb_prio_low_bit(lo), .i_ep_pingpong(pp), .i_ep_iso(iso),
    .i_stall_request(sr), .i_in_ack_ev(p[0]), .i_out_bank0_ev(p[1]), .i_out_bank1_ev(p[2]), .i_setup_ev(p[3]),
    .i_stall_ev(p[4]), .i_sof_ev(p[10][0]), .i_in_sent_clr(p[5]), .i_out_bank0_clr(p[6]), .i_out_bank1_clr(p[7]),
    .i_setup_received_clr(p[8]), .i_stall_sent_clr(p[9]), .i_frame_start_clr(p[11][0]), .i_wake_cpu_clr(p[11][1]),
    .i_suspend_clr(p[11][2]), .i_ep_irq_en(ie), .i_bus_irq_en(3'b111), .i_dp(dp), .i_dm(dm),
    .o_in_sent_flag(fi), .o_out_bank0_flag(f0), .o_out_bank1_flag(f1), .o_setup_received_flag(fs),
    .o_stall_sent_flag(fst), .o_frame_start_flag(fr), .o_wake_cpu_flag(fw), .o_suspend_flag(fsp), .o_usb_irq(irq),
    .o_usb_irq_prio(pr), .o_ctrl_rst(crst), .o_xcvr_en(xen), .o_usb_clk_en(cen), .o_bus_reset(brst),
    .o_dp(odp), .o_dm(odm), .o_pad_oe(poe));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic close_out;
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setm(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
  endtask
  function automatic logic sel(input int s);
    return s == 0 ? fsp : s == 1 ? fw : s == 2 ? poe : s == 3 ? brst : !poe;
  endfunction
  // Bounded wait; a hang is reported and ends the run
  task automatic wt(input int s);
    for (k = 0; k < 200 && sel(s) !== 1'b1; k++)
      cyc(1);
    if (k == 200)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: wait %0d timed out", $time, s);
      close_out;
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ad <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdv, e);
  endtask
  task automatic pls(input int i, input logic [7:0] m);
    @(posedge clk);
    p[i] <= m;
    @(posedge clk);
    p[i] <= 8'h00;
    cyc(1);
  endtask
  task automatic t_reg;
    rdr(8'hbc, 8'h00);
    wrr(8'hbd, 8'h80);
    rdr(8'hbd, 8'h00);
    rdr(8'hbc, 8'h00);
    wrr(8'hbc, 8'h80);
    rdr(8'hbc, 8'h80);
    chk({crst, xen, cen}, 8'h03);
  endtask
  task automatic t_prio;
    for (int v = 0; v < 4; v++)
    begin
      @(posedge clk);
      {hi, lo} <= v[1:0];
      cyc(2);
      chk(pr, v[7:0]);
    end
  endtask
  task automatic t_ev;
    pls(3, 8'h01);
    chk(fs, 8'h01);
    chk(irq, 8'h01);
    pls(8, 8'h01);
    chk(irq, 8'h00);
    pls(0, 8'h02);
    cyc(5);
    chk(fi, 8'h02);
    pls(1, 8'h04);
    chk(f0, 8'h04);
    pls(2, 8'h18);
    chk(f1, 8'h10);
    pls(4, 8'h61);
    chk(fst, 8'h20);
    pls(3, 8'h20);
    chk(fst, 8'h00);
    chk(fs, 8'h20);
    pls(10, 8'h01);
    chk(fr, 8'h01);
    pls(11, 8'h01);
    chk(fr, 8'h00);
    pls(10, 8'h01);
    chk(fr, 8'h01);
    for (int i = 5; i < 12; i++)
      pls(i, 8'hff);
    chk(irq, 8'h00);
  endtask
  task automatic t_susp;
    setm(2'd0);
    cyc(15);
    chk(fsp, 8'h00);
    wt(0);
    wrr(8'hbc, 8'hc0);
    cyc(2);
    chk(cen, 8'h00);
    chk(irq, 8'h01);
    setm(2'd2);
    wt(1);
    setm(2'd3);
    wrr(8'hbc, 8'h80);
    pls(11, 8'h06);
  endtask
  task automatic t_wake;
    wrr(8'hbc, 8'h84);
    setm(2'd0);
    wt(0);
    pls(11, 8'h04);
    wrr(8'hbc, 8'ha4);
    cyc(2);
    chk(poe, 8'h00);
    wt(2);
    chk({odp, odm}, 8'h01);
    rdr(8'hbc, 8'hac);
    wt(4);
    rdr(8'hbc, 8'ha4);
    wrr(8'hbc, 8'h84);
    setm(2'd3);
  endtask
  task automatic t_brst;
    wrr(8'hbc, 8'h87);
    setm(2'd1);
    wt(3);
    setm(2'd3);
    rdr(8'hbc, 8'h84);
  endtask
  task automatic t_dis;
    pls(3, 8'h01);
    wrr(8'hbc, 8'h00);
    cyc(2);
    chk({crst, xen, cen}, 8'h04);
    chk(pr, 8'h03);
    chk(fs, 8'h00);
    pls(3, 8'h01);
    chk(fs, 8'h00);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_reg;
    t_prio;
    t_ev;
    t_susp;
    t_wake;
    t_brst;
    t_dis;
    close_out;
  end
endmodule // tb_usb_event_and_global_control
